// ### src/spt_track.sv
// Stack-pointer tracker with partial-write merge tracking.
// Assumes decode/dispatch offers at most one op per cycle in program order,
// from logic on the same clock; results appear one enabled cycle later.
//
// Notes on behaviour
// [RQ1] follow stack pointer so pushes/pops run parallel
// [RQ2] calls, returns, teardown, sp reads need no sync
// [RQ3] address_compute or sp destination keeps true dependency
// [RQ4] indexed sp memory or microcoded sp keeps dependency
// [RQ5] partial writes merge with untouched register bits
// [RQ6] partial write depends on last writer of register
// [RQ7] integer register tracked as one 64-bit entity
// [RQ8] 32-bit integer write zeroes upper, no merge
// [RQ9] vector register one 128-bit entity; halves merge
// [RQ10] 32-bit vector slice write merges with rest
// [RQ11] scalar moves from memory zero upper, no merge
// [RQ12] frame_teardown is one byte, two below epilogue
// [RQ13] teardown copies frame_base_reg to sp, then pops
// [RQ14] tracking never changes architectural results
`timescale 1ns/1ps
`default_nettype none
module spt_track #(
    parameter int SLOT = spt_pkg::SLOT_BYTES
) (
    input  wire logic                          clock,
    input  wire logic                          rst,
    input  wire logic                          ce,
    input  wire logic                          inValid,
    input  wire logic [spt_pkg::TAG_W-1:0]     inTag,
    input  wire spt_pkg::spt_kind_t            inKind,
    input  wire logic                          inWritesSp,
    input  wire logic [15:0]                   inRetImm,
    input  wire logic [spt_pkg::REG_W-1:0]     inDestReg,
    input  wire spt_pkg::spt_width_t           inDestWidth,
    input  wire logic                          inZeroLoad,
    output logic                               outValid,
    output logic [spt_pkg::TAG_W-1:0]          outTag,
    output logic                               outNeedSync,
    output logic [spt_pkg::TAG_W-1:0]          outBaseTag,
    output logic                               outBaseValid,
    output logic                               outBaseFrame,
    output logic signed [spt_pkg::OFF_W-1:0]   outSpOffset,
    output logic [spt_pkg::LEN_W-1:0]          outLenBytes,
    output logic                               outMergeValid,
    output logic [spt_pkg::TAG_W-1:0]          outMergeTag
);
    // ------------------------------------------------------------
    // tracked state
    // ------------------------------------------------------------
    // the stack pointer seen by the next op is base + delta, where base is
    // the result of the last op that wrote the pointer whole (or the reset
    // value when baseValid is low)
    localparam logic signed [spt_pkg::OFF_W-1:0] SLOT_OFF = spt_pkg::OFF_W'(SLOT);
    localparam logic [spt_pkg::LEN_W-1:0] TD_LEN = spt_pkg::LEN_W'(spt_pkg::TEARDOWN_LEN_BYTES);

    logic signed [spt_pkg::OFF_W-1:0] delta_q;
    logic signed [spt_pkg::OFF_W-1:0] delta_d;
    logic signed [spt_pkg::OFF_W-1:0] access_d;
    logic [spt_pkg::TAG_W-1:0]        baseTag_q;
    logic                             baseValid_q;
    logic                             take;

    assign take = ce && inValid;

    // ------------------------------------------------------------
    // offset arithmetic
    // ------------------------------------------------------------
    always_comb begin
        delta_d  = delta_q;
        access_d = delta_q;
        case (inKind)
            spt_pkg::SPT_PUSH,
            spt_pkg::SPT_CALL: begin
                access_d = delta_q - SLOT_OFF;                          // RQ1 RQ2
                delta_d  = delta_q - SLOT_OFF;
            end
            spt_pkg::SPT_POP: begin
                delta_d = delta_q + SLOT_OFF;                           // RQ1
            end
            spt_pkg::SPT_RET: begin
                // return with immediate also drops the argument bytes
                delta_d = delta_q + SLOT_OFF + spt_pkg::OFF_W'(inRetImm); // RQ2
            end
            spt_pkg::SPT_TEARDOWN: begin
                // pop off the frame base copy, so offset 0 then one slot up
                access_d = '0;                                          // RQ13
                delta_d  = SLOT_OFF;                                    // RQ13
            end
            default: begin
                access_d = delta_q;
                delta_d  = delta_q;
            end
        endcase
        // a whole write of the pointer restarts the offset at its result
        if (inWritesSp && inKind != spt_pkg::SPT_TEARDOWN) begin
            delta_d = '0;                                               // RQ3 RQ14
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            delta_q <= '0;
        end else if (take) begin
            delta_q <= delta_d;                                         // RQ1 RQ14
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            baseTag_q   <= spt_pkg::TAG_RESET;
            baseValid_q <= 1'b0;
        end else if (take && (inWritesSp || inKind == spt_pkg::SPT_TEARDOWN)) begin
            baseTag_q   <= inTag;                                       // RQ3 RQ13
            baseValid_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // per-op answer
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            outValid     <= 1'b0;
            outTag       <= spt_pkg::TAG_RESET;
            outNeedSync  <= 1'b0;
            outBaseTag   <= spt_pkg::TAG_RESET;
            outBaseValid <= 1'b0;
            outBaseFrame <= 1'b0;
            outSpOffset  <= '0;
            outLenBytes  <= '0;
        end else if (ce) begin
            outValid     <= inValid;
            outTag       <= inTag;
            // sync ops wait for the real pointer; tracked ones only need base
            outNeedSync  <= inValid && spt_pkg::isSyncKind(inKind);     // RQ3 RQ4
            outBaseTag   <= baseTag_q;
            outBaseValid <= baseValid_q;
            // teardown reads frame_base_reg, not the old pointer
            outBaseFrame <= inValid && inKind == spt_pkg::SPT_TEARDOWN; // RQ2 RQ13
            outSpOffset  <= access_d;                                   // RQ14
            outLenBytes  <= (inValid && inKind == spt_pkg::SPT_TEARDOWN) ? TD_LEN
                                                                         : '0; // RQ12
        end
    end

    // ------------------------------------------------------------
    // merge tracking
    // ------------------------------------------------------------
    spt_merge_if mif ();

    assign mif.wrValid    = take;
    assign mif.wrReg      = inDestReg;
    assign mif.wrWidth    = inDestWidth;
    assign mif.wrZeroLoad = inZeroLoad;
    assign mif.wrTag      = inTag;

    spt_merge_dep u_merge (
        .clock (clock),
        .rst   (rst),
        .ce    (ce),
        .mif   (mif.lookup)
    );

    assign outMergeValid = mif.depValid;                                // RQ5
    assign outMergeTag   = mif.depTag;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    push_offset_a: assert property (@(posedge clock) disable iff (rst) // RQ1
        (take && inKind == spt_pkg::SPT_PUSH && !inWritesSp)
        |=> (outSpOffset == $past(delta_q) - SLOT_OFF && delta_q == outSpOffset))
        else $error("push offset not one slot below the tracked pointer");

    pop_chain_a: assert property (@(posedge clock) disable iff (rst) // RQ1
        (take && inKind == spt_pkg::SPT_POP && !inWritesSp)
        ##1 (take && inKind == spt_pkg::SPT_POP && !inWritesSp)
        |=> delta_q == $past(delta_q, 2) + SLOT_OFF + SLOT_OFF)
        else $error("two pops did not raise the pointer two slots");

    tracked_free_a: assert property (@(posedge clock) disable iff (rst) // RQ2
        (take && spt_pkg::isTrackedKind(inKind)) |=> (outValid && !outNeedSync))
        else $error("tracked stack op was made to wait for the pointer");

    sync_kept_a: assert property (@(posedge clock) disable iff (rst) // RQ3
        (take && spt_pkg::isSyncKind(inKind)) |=> (outNeedSync && outTag == $past(inTag)))
        else $error("dependency on the pointer was dropped");

    rebase_after_write_a: assert property (@(posedge clock) disable iff (rst) // RQ14
        (take && inWritesSp && inKind == spt_pkg::SPT_SP_DEST)
        |=> (delta_q == '0 && baseValid_q && baseTag_q == $past(inTag)))
        else $error("pointer write did not restart the tracked offset");

    teardown_pop_a: assert property (@(posedge clock) disable iff (rst) // RQ13
        (take && inKind == spt_pkg::SPT_TEARDOWN)
        |=> (outBaseFrame && outSpOffset == '0 && delta_q == SLOT_OFF
             && outLenBytes == TD_LEN))
        else $error("teardown did not copy frame base and pop");

    pop_offset_a: assert property (@(posedge clock) disable iff (rst) // RQ1
        (take && inKind == spt_pkg::SPT_POP && !inWritesSp)
        |=> (outSpOffset == $past(delta_q) && delta_q == $past(delta_q) + SLOT_OFF))
        else $error("pop did not read at the tracked pointer and raise it");

    ret_release_a: assert property (@(posedge clock) disable iff (rst) // RQ2
        (take && inKind == spt_pkg::SPT_RET && !inWritesSp)
        |=> (delta_q == $past(delta_q) + SLOT_OFF + spt_pkg::OFF_W'($past(inRetImm))))
        else $error("return did not release its slot and argument bytes");

    read_only_hold_a: assert property (@(posedge clock) disable iff (rst) // RQ2
        (take && !inWritesSp && (inKind == spt_pkg::SPT_SP_SRC ||
                                 inKind == spt_pkg::SPT_SP_MEM_NOIDX))
        |=> (outSpOffset == $past(delta_q) && $stable(delta_q) && $stable(baseTag_q)))
        else $error("pointer read moved the tracked pointer");

    freeze_hold_a: assert property (@(posedge clock) disable iff (rst) // RQ14
        !ce |=> ($stable(delta_q) && $stable(outValid) && $stable(outTag)
                 && $stable(outSpOffset)))
        else $error("state moved while the clock enable was low");
endmodule
`default_nettype wire

// ### shared/spt_pkg.sv
// Package for the stack-pointer tracker and partial-write merge logic.
// Assumes one op per cycle arrives from decode/dispatch, in program order.
package spt_pkg;

    // ------------------------------------------------------------
    // sizes and encodings
    // ------------------------------------------------------------
    localparam int SLOT_BYTES         = 8;    // stack slot of a push/pop in 64-bit mode
    localparam int TEARDOWN_LEN_BYTES = 1;    // frame_teardown encoding length
    localparam int EPILOGUE_LEN_BYTES = 3;    // copy-to-sp plus pop, the long form
    localparam int GPR_COUNT          = 16;
    localparam int VEC_COUNT          = 16;
    localparam int GPR_BITS           = 64;
    localparam int VEC_BITS           = 128;
    localparam int TAG_W              = 6;
    localparam int OFF_W              = 20;
    localparam int REG_W              = 4;
    localparam int LEN_W              = 4;
    localparam logic [TAG_W-1:0] TAG_RESET = 6'h00;

    typedef enum logic [3:0] {
        SPT_OTHER,
        SPT_PUSH,
        SPT_POP,
        SPT_CALL,
        SPT_RET,
        SPT_TEARDOWN,
        SPT_SP_SRC,
        SPT_SP_MEM_NOIDX,
        SPT_SP_LEA,
        SPT_SP_DEST,
        SPT_SP_MEM_IDX,
        SPT_SP_MICRO
    } spt_kind_t;

    // part of the destination that an op writes
    typedef enum logic [3:0] {
        SPT_W_NONE,
        SPT_W_GPR8,
        SPT_W_GPR16,
        SPT_W_GPR32,
        SPT_W_GPR64,
        SPT_W_VEC32,
        SPT_W_VEC64LO,
        SPT_W_VEC64HI,
        SPT_W_VEC128
    } spt_width_t;

    // ------------------------------------------------------------
    // classification
    // ------------------------------------------------------------
    function automatic logic isSyncKind(spt_kind_t k);
        return (k == SPT_SP_LEA) || (k == SPT_SP_DEST) ||
               (k == SPT_SP_MEM_IDX) || (k == SPT_SP_MICRO);
    endfunction

    function automatic logic isTrackedKind(spt_kind_t k);
        return (k == SPT_PUSH) || (k == SPT_POP) || (k == SPT_CALL) ||
               (k == SPT_RET) || (k == SPT_TEARDOWN) || (k == SPT_SP_SRC) ||
               (k == SPT_SP_MEM_NOIDX);
    endfunction

endpackage

// ### shared/spt_merge_if.sv
// Interface between the tracker and the register merge table.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface spt_merge_if;
    logic                          wrValid;
    logic [spt_pkg::REG_W-1:0]     wrReg;
    spt_pkg::spt_width_t           wrWidth;
    logic                          wrZeroLoad;
    logic [spt_pkg::TAG_W-1:0]     wrTag;
    logic                          depValid;
    logic [spt_pkg::TAG_W-1:0]     depTag;

    modport requester (output wrValid, wrReg, wrWidth, wrZeroLoad, wrTag,
                       input depValid, depTag);
    modport lookup (input wrValid, wrReg, wrWidth, wrZeroLoad, wrTag,
                    output depValid, depTag);
endinterface
`default_nettype wire

// ### src/spt_merge_dep.sv
// Last-writer table for integer and vector registers; reports merge
// dependencies of partial writes one cycle after the write is offered.
// Assumes writes arrive in program order from the tracker.
`timescale 1ns/1ps
`default_nettype none
module spt_merge_dep (
    input  wire logic   clock,
    input  wire logic   rst,
    input  wire logic   ce,
    spt_merge_if.lookup mif
);
    // ------------------------------------------------------------
    // table: one entry per whole register, not per slice
    // ------------------------------------------------------------
    localparam int ENTRIES = spt_pkg::GPR_COUNT + spt_pkg::VEC_COUNT;

    logic [spt_pkg::TAG_W-1:0] lastTag_q [ENTRIES];
    logic [ENTRIES-1:0]        lastValid_q;
    logic                      depValid_q;
    logic [spt_pkg::TAG_W-1:0] depTag_q;

    function automatic logic needsMerge(spt_pkg::spt_width_t w, logic zeroLoad);
        case (w)
            spt_pkg::SPT_W_GPR8,
            spt_pkg::SPT_W_GPR16:   return 1'b1;                    // RQ8
            spt_pkg::SPT_W_VEC64HI: return 1'b1;                    // RQ9
            spt_pkg::SPT_W_VEC32,
            spt_pkg::SPT_W_VEC64LO: return !zeroLoad;               // RQ10 RQ11
            default:                return 1'b0;                    // RQ8
        endcase
    endfunction

    function automatic logic isVec(spt_pkg::spt_width_t w);
        return (w == spt_pkg::SPT_W_VEC32) || (w == spt_pkg::SPT_W_VEC64LO) ||
               (w == spt_pkg::SPT_W_VEC64HI) || (w == spt_pkg::SPT_W_VEC128);
    endfunction

    logic [4:0] slot;
    assign slot = {isVec(mif.wrWidth), mif.wrReg};                  // RQ7 RQ9

    always_ff @(posedge clock) begin
        if (rst) begin
            lastValid_q <= '0;
        end else if (ce && mif.wrValid && mif.wrWidth != spt_pkg::SPT_W_NONE) begin
            lastValid_q[slot] <= 1'b1;                              // RQ6
        end
    end

    always_ff @(posedge clock) begin
        if (ce && mif.wrValid && mif.wrWidth != spt_pkg::SPT_W_NONE) begin
            lastTag_q[slot] <= mif.wrTag;                           // RQ6
        end
    end

    // the merging op waits on whoever last wrote any part of the register
    always_ff @(posedge clock) begin
        if (rst) begin
            depValid_q <= 1'b0;
            depTag_q   <= spt_pkg::TAG_RESET;
        end else if (ce) begin
            depValid_q <= mif.wrValid && lastValid_q[slot] &&
                          needsMerge(mif.wrWidth, mif.wrZeroLoad);  // RQ5 RQ6
            depTag_q   <= lastTag_q[slot];
        end
    end

    assign mif.depValid = depValid_q;
    assign mif.depTag   = depTag_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    gpr32_no_merge_a: assert property (@(posedge clock) disable iff (rst) // RQ8
        (ce && mif.wrValid && mif.wrWidth == spt_pkg::SPT_W_GPR32) |=> !mif.depValid)
        else $error("32-bit integer write reported a merge");

    narrow_merge_a: assert property (@(posedge clock) disable iff (rst) // RQ6
        (ce && mif.wrValid && mif.wrWidth == spt_pkg::SPT_W_GPR8 && lastValid_q[slot])
        |=> (mif.depValid && mif.depTag == $past(lastTag_q[slot])))
        else $error("byte write lost its merge on the last writer");

    vec_load_zero_a: assert property (@(posedge clock) disable iff (rst) // RQ11
        (ce && mif.wrValid && mif.wrZeroLoad && mif.wrWidth == spt_pkg::SPT_W_VEC64LO)
        |=> !mif.depValid)
        else $error("zeroing vector load reported a merge");
endmodule
`default_nettype wire

// ### tb/spt_decode_model.sv
// Behavioural decode/dispatch stream feeding the tracker, one op per call.
// Assumes callers invoke its tasks just after a falling clock edge.
`timescale 1ns/1ps
`default_nettype none
module spt_decode_model (
    output logic                      inValid,
    output logic [5:0]                inTag,
    output spt_pkg::spt_kind_t        inKind,
    output logic                      inWritesSp,
    output logic [15:0]               inRetImm,
    output logic [3:0]                inDestReg,
    output spt_pkg::spt_width_t       inDestWidth,
    output logic                      inZeroLoad
);
    task automatic put(input spt_pkg::spt_kind_t k, input logic [5:0] t, input logic ws,
                       input logic [15:0] imm, input logic [3:0] r,
                       input spt_pkg::spt_width_t w, input logic zl);
        inValid     = 1'b1;
        inTag       = t;
        inKind      = k;
        inWritesSp  = ws;
        inRetImm    = imm;
        inDestReg   = r;
        inDestWidth = w;
        inZeroLoad  = zl;
    endtask

    // no op: tag, immediate, register and zero-load flip to junk (kind, sp write and width hold) so a sloppy valid qualifier shows up
    task automatic idle();
        inValid    = 1'b0;
        inTag      = ~inTag;
        inRetImm   = ~inRetImm;
        inDestReg  = ~inDestReg;
        inZeroLoad = ~inZeroLoad;
    endtask

    initial begin
        inTag       = 6'h2A;
        inKind      = spt_pkg::SPT_PUSH;
        inWritesSp  = 1'b0;
        inRetImm    = 16'h5A5A;
        inDestReg   = 4'h3;
        inDestWidth = spt_pkg::SPT_W_GPR8;
        inZeroLoad  = 1'b0;
        idle();
    end
endmodule
`default_nettype wire

// ### tb/spt_track_tb.sv
// Self-checking bench for the stack-pointer tracker and merge logic.
// Assumes the decode model drives ops at falling edges; checks one cycle later.
`timescale 1ns/1ps
`default_nettype none
`define SPT_CHK(what, exp, got) begin nChecks++; if ((got) !== (exp)) begin nFail++; \
    $display("unexpected %s exp %0h got %0h", what, exp, got); end end
module spt_track_tb;
    localparam int SLOT = 8;
    logic clock, rst, ce, inValid, inWritesSp, inZeroLoad;
    logic outValid, outNeedSync, outBaseValid, outBaseFrame, outMergeValid;
    logic [5:0] inTag, outTag, outBaseTag, outMergeTag;
    logic [15:0] inRetImm;
    logic [3:0] inDestReg, outLenBytes;
    logic signed [19:0] outSpOffset;
    spt_pkg::spt_kind_t inKind;
    spt_pkg::spt_width_t inDestWidth;
    int nFail = 0;
    int nChecks = 0;

    spt_decode_model i_model (.inValid(inValid), .inTag(inTag), .inKind(inKind),
        .inWritesSp(inWritesSp), .inRetImm(inRetImm), .inDestReg(inDestReg),
        .inDestWidth(inDestWidth), .inZeroLoad(inZeroLoad));
    spt_track #(.SLOT(SLOT)) i_dut (.clock(clock), .rst(rst), .ce(ce), .inValid(inValid),
        .inTag(inTag), .inKind(inKind), .inWritesSp(inWritesSp), .inRetImm(inRetImm),
        .inDestReg(inDestReg), .inDestWidth(inDestWidth), .inZeroLoad(inZeroLoad),
        .outValid(outValid), .outTag(outTag), .outNeedSync(outNeedSync),
        .outBaseTag(outBaseTag), .outBaseValid(outBaseValid), .outBaseFrame(outBaseFrame),
        .outSpOffset(outSpOffset), .outLenBytes(outLenBytes),
        .outMergeValid(outMergeValid), .outMergeTag(outMergeTag));

    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    // ----------------------------------------------------------------
    // shared drivers and checks
    // ----------------------------------------------------------------
    task automatic completeRun();
        $display("checks %0d mismatches %0d", nChecks, nFail);
        if (nFail == 0 && nChecks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic sp(input spt_pkg::spt_kind_t k, input logic [5:0] t,
                      input logic ws = 1'b0, input logic [15:0] imm = 16'h0000);
        i_model.put(k, t, ws, imm, 4'h0, spt_pkg::SPT_W_NONE, 1'b0);
        @(negedge clock);
    endtask

    task automatic mg(input logic [5:0] t, input logic [3:0] r,
                      input spt_pkg::spt_width_t w, input logic zl = 1'b0);
        i_model.put(spt_pkg::SPT_OTHER, t, 1'b0, 16'h0000, r, w, zl);
        @(negedge clock);
    endtask

    task automatic expSp(input logic [5:0] t, input logic sync, input int off);
        `SPT_CHK("outValid", 1'b1, outValid)
        `SPT_CHK("outTag", t, outTag)
        `SPT_CHK("outNeedSync", sync, outNeedSync)
        `SPT_CHK("outSpOffset", 20'(off), outSpOffset)
    endtask

    task automatic expMg(input logic v, input logic [5:0] t);
        `SPT_CHK("outMergeValid", v, outMergeValid)
        if (v) `SPT_CHK("outMergeTag", t, outMergeTag)
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic pushPopBurst();
        sp(spt_pkg::SPT_PUSH, 6'h01); expSp(6'h01, 1'b0, -SLOT);
        `SPT_CHK("outBaseValid", 1'b0, outBaseValid)
        sp(spt_pkg::SPT_PUSH, 6'h02); expSp(6'h02, 1'b0, -2*SLOT);
        sp(spt_pkg::SPT_POP, 6'h03); expSp(6'h03, 1'b0, -2*SLOT);
        sp(spt_pkg::SPT_POP, 6'h04); expSp(6'h04, 1'b0, -SLOT);
    endtask

    task automatic trackedKinds();
        sp(spt_pkg::SPT_CALL, 6'h05); expSp(6'h05, 1'b0, -SLOT);
        sp(spt_pkg::SPT_SP_SRC, 6'h06); expSp(6'h06, 1'b0, -SLOT);
        sp(spt_pkg::SPT_SP_MEM_NOIDX, 6'h07); expSp(6'h07, 1'b0, -SLOT);
        // return with immediate releases the slot plus 16 extra bytes
        sp(spt_pkg::SPT_RET, 6'h08, 1'b0, 16'h0010); expSp(6'h08, 1'b0, -SLOT);
        sp(spt_pkg::SPT_SP_SRC, 6'h09); expSp(6'h09, 1'b0, 16);
    endtask

    task automatic syncKinds();
        sp(spt_pkg::SPT_SP_LEA, 6'h0A); expSp(6'h0A, 1'b1, 16);
        sp(spt_pkg::SPT_SP_MEM_IDX, 6'h0B); expSp(6'h0B, 1'b1, 16);
        sp(spt_pkg::SPT_SP_MICRO, 6'h0C); expSp(6'h0C, 1'b1, 16);
        sp(spt_pkg::SPT_SP_DEST, 6'h0D, 1'b1); expSp(6'h0D, 1'b1, 16);
        sp(spt_pkg::SPT_SP_SRC, 6'h0E); expSp(6'h0E, 1'b0, 0);
        `SPT_CHK("outBaseTag", 6'h0D, outBaseTag)
        `SPT_CHK("outBaseValid", 1'b1, outBaseValid)
    endtask

    task automatic teardown();
        sp(spt_pkg::SPT_TEARDOWN, 6'h0F); expSp(6'h0F, 1'b0, 0);
        `SPT_CHK("outBaseFrame", 1'b1, outBaseFrame)
        `SPT_CHK("outLenBytes", 4'h1, outLenBytes)
        sp(spt_pkg::SPT_PUSH, 6'h10); expSp(6'h10, 1'b0, 0);
        `SPT_CHK("outBaseTag", 6'h0F, outBaseTag)
        `SPT_CHK("outBaseFrame", 1'b0, outBaseFrame)
        `SPT_CHK("outLenBytes", 4'h0, outLenBytes)
    endtask

    task automatic gprMerge();
        mg(6'h14, 4'h3, spt_pkg::SPT_W_GPR64); expMg(1'b0, 6'h00);
        mg(6'h15, 4'h3, spt_pkg::SPT_W_GPR8); expMg(1'b1, 6'h14);
        mg(6'h16, 4'h3, spt_pkg::SPT_W_GPR16); expMg(1'b1, 6'h15);
        mg(6'h17, 4'h3, spt_pkg::SPT_W_GPR32); expMg(1'b0, 6'h00);
        mg(6'h18, 4'h3, spt_pkg::SPT_W_GPR8); expMg(1'b1, 6'h17);
        mg(6'h19, 4'h4, spt_pkg::SPT_W_GPR8); expMg(1'b0, 6'h00);
    endtask

    task automatic vecMerge();
        // same index as the integer writes above: files must stay apart
        mg(6'h1E, 4'h3, spt_pkg::SPT_W_VEC128); expMg(1'b0, 6'h00);
        mg(6'h1F, 4'h3, spt_pkg::SPT_W_VEC64HI); expMg(1'b1, 6'h1E);
        mg(6'h20, 4'h3, spt_pkg::SPT_W_VEC64LO); expMg(1'b1, 6'h1F);
        mg(6'h21, 4'h3, spt_pkg::SPT_W_VEC32); expMg(1'b1, 6'h20);
        mg(6'h22, 4'h3, spt_pkg::SPT_W_VEC64LO, 1'b1); expMg(1'b0, 6'h00);
        mg(6'h23, 4'h3, spt_pkg::SPT_W_VEC32, 1'b1); expMg(1'b0, 6'h00);
        mg(6'h24, 4'h3, spt_pkg::SPT_W_VEC64LO); expMg(1'b1, 6'h23);
    endtask

    task automatic freezeAndReset();
        sp(spt_pkg::SPT_OTHER, 6'h27);
        ce = 1'b0;
        sp(spt_pkg::SPT_PUSH, 6'h28); expSp(6'h27, 1'b0, 0);
        ce = 1'b1;
        @(negedge clock); expSp(6'h28, 1'b0, -SLOT);
        rst = 1'b1;
        sp(spt_pkg::SPT_PUSH, 6'h29);
        `SPT_CHK("outValid", 1'b0, outValid)
        rst = 1'b0;
        sp(spt_pkg::SPT_PUSH, 6'h2A); expSp(6'h2A, 1'b0, -SLOT);
        mg(6'h2B, 4'h3, spt_pkg::SPT_W_GPR8); expMg(1'b0, 6'h00);
        i_model.idle();
    endtask

    initial begin
        rst = 1'b1;
        ce  = 1'b1;
        repeat (20) @(negedge clock);
        rst = 1'b0;
        pushPopBurst();
        trackedKinds();
        syncKinds();
        teardown();
        gprMerge();
        vecMerge();
        freezeAndReset();
        repeat (2) @(negedge clock);
        completeRun();
    end

    // a hung run is cut short and counted as a mismatch
    initial begin
        repeat (5000) @(posedge clock);
        nFail++;
        completeRun();
    end
endmodule
`default_nettype wire
